// >>> src/heartbeat_pkg.sv
// Constants, types and register map of the heartbeat error-control block
package heartbeat_pkg;

  localparam int NUM_SLOTS = 4;

  // Object indices; byte address is four times the index
  localparam logic [15:0] IDX_CONS_SLOTS   = 16'h1016;
  localparam logic [15:0] IDX_PROD_PERIOD  = 16'h1017;
  localparam logic [31:0] ADDR_CONS_COUNT  = {14'h0000, IDX_CONS_SLOTS, 2'b00};
  localparam logic [31:0] ADDR_PROD_PERIOD = {14'h0000, IDX_PROD_PERIOD, 2'b00};
  localparam logic [31:0] ADDR_SLOT_BASE   = 32'h0000_4060;
  localparam logic [31:0] ADDR_STATUS      = 32'h0000_4070;

  // Consumer slot word layout
  localparam int SLOT_TIME_LSB = 0;
  localparam int SLOT_TIME_W   = 16;
  localparam int SLOT_NODE_LSB = 16;
  localparam int SLOT_NODE_W   = 8;

  // Status word layout
  localparam int ST_ERR_LSB      = 0;
  localparam int ST_ARMED_LSB    = 4;
  localparam int ST_ALARM_BIT    = 8;
  localparam int ST_STATE_LSB    = 16;
  localparam int ST_CONFLICT_BIT = 24;

  // Reset and fixed values
  localparam logic [31:0] CONS_COUNT_VAL   = 32'h0000_0004;
  localparam logic [31:0] SLOT_RESET       = 32'h0000_0000;
  localparam logic [15:0] PROD_RESET       = 16'h0000;
  localparam logic [10:0] HB_ID_BASE       = 11'h700;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  // Network-management command codes
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP  = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;

  // Millisecond tick
  localparam int          TICK_PERIOD_NS  = 1000000;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          TICK_W          = 18;

  typedef enum logic [6:0] {
    NODE_STOPPED     = 7'h04,
    NODE_OPERATIONAL = 7'h05,
    NODE_PREOP       = 7'h7f
  } node_state_e;

  typedef struct packed {
    logic [10:0] id;
    logic [7:0]  data;
  } can_frame_s;

endpackage : heartbeat_pkg

// >>> src/heartbeat_error_control.sv
// Heartbeat producer and four-slot consumer with AHB-Lite register access
//
// Notes on behaviour
// RULE_01 - Four independent consumer slots, each with its own configuration word.
// RULE_02 - Slot word: top byte reserved, next byte node id, low half timeout.
// RULE_03 - Consumer timeout counts in one-millisecond units.
// RULE_04 - Zero timeout disables the slot; it never raises an error.
// RULE_05 - Supervision starts only after the first heartbeat from the watched node.
// RULE_06 - Slot timeout forces preoperational state and raises the communication-loss alarm.
// RULE_07 - Producer sends one heartbeat each time its millisecond period elapses.
// RULE_08 - Producer period zero disables heartbeat transmission.
// RULE_09 - Heartbeat id is 700h plus own node id; byte holds zero then state.
// RULE_10 - Production and consumption stay active in the stopped state.
// RULE_11 - Writing a non-zero configuration after an error clears the alarm.
// RULE_12 - Heartbeat and node guarding never run together on one node.
// RULE_13 - Configurer sets consumer timeouts above, ideally multiples of, producer period.
// RULE_14 - Communication objects return to defaults on every reset.
// RULE_15 - Consumer sub-index zero is read-only and returns four.
// RULE_16 - Timeouts and producer period reset to zero; services start disabled.
// RULE_17 - State codes: stopped 4, operational 5, preoperational 127.
// RULE_18 - In stopped state only network management traffic; process and service data silent.
// RULE_19 - Matching heartbeat restarts its slot timer from the programmed value.
// RULE_20 - All timers run on a common millisecond tick and clear on reset.
`timescale 1ns/100ps

module heartbeat_error_control
  import heartbeat_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Node identity and management
  input  wire logic [6:0]  node_id_i,
  input  wire logic        nmt_cmd_valid_i,
  input  wire logic [7:0]  nmt_cmd_i,
  input  wire logic        guard_enable_i,
  output node_state_e      node_state_o,
  output logic             pdo_sdo_enable_o,
  output logic             comm_loss_alarm_o,
  // Received frames from the CAN controller
  input  wire logic        rx_valid_i,
  input  wire can_frame_s  rx_frame_i,
  // Heartbeat frames to the CAN controller
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output can_frame_s       tx_frame_o
);

  function automatic logic [2:0] slot_dec(input logic [31:0] a);
    slot_dec = {(a[31:4] == ADDR_SLOT_BASE[31:4]) && (a[1:0] == 2'b00), a[3:2]};
  endfunction : slot_dec

  function automatic logic [10:0] hb_id(input logic [7:0] node);
    hb_id = HB_ID_BASE + {3'b000, node};
  endfunction : hb_id

  // Bus and configuration state
  logic                 act_q,     act_d;
  logic                 wr_q,      wr_d;
  logic [31:0]          addr_q,    addr_d;
  logic [31:0]          rdata_q,   rdata_d;
  logic [31:0]          slot_cfg_q [NUM_SLOTS];
  logic [31:0]          slot_cfg_d [NUM_SLOTS];
  logic [15:0]          period_q,  period_d;
  logic [NUM_SLOTS-1:0] slot_wr;
  logic                 prod_wr;
  logic [2:0]           rd_slot;
  logic [2:0]           wr_slot;

  // Timer state
  logic [TICK_W-1:0]    tick_cnt_q, tick_cnt_d;
  logic [15:0]          prod_cnt_q, prod_cnt_d;
  logic [15:0]          cons_timer_q [NUM_SLOTS];
  logic [15:0]          cons_timer_d [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] armed_q,   armed_d;
  logic [NUM_SLOTS-1:0] err_q,     err_d;
  logic                 alarm_q,   alarm_d;
  node_state_e          state_q,   state_d;
  logic                 tx_pend_q, tx_pend_d;
  can_frame_s           tx_frame_q, tx_frame_d;
  logic                 tick;
  logic                 hb_active;
  logic                 send;
  logic                 rearm;
  logic [NUM_SLOTS-1:0] slot_hit;
  logic [NUM_SLOTS-1:0] expire;
  logic [31:0]          status_word;

  assign hreadyout_o       = 1'b1;
  assign hresp_o           = 1'b0;
  assign hrdata_o          = rdata_q;
  assign node_state_o      = state_q;
  assign comm_loss_alarm_o = alarm_q;
  assign tx_valid_o        = tx_pend_q;
  assign tx_frame_o        = tx_frame_q;
  assign pdo_sdo_enable_o  = (state_q != NODE_STOPPED);  // [RULE_18]

  always_comb
  begin
    status_word = '0;
    status_word[ST_ERR_LSB +: NUM_SLOTS]   = err_q;
    status_word[ST_ARMED_LSB +: NUM_SLOTS] = armed_q;
    status_word[ST_ALARM_BIT]              = alarm_q;
    status_word[ST_STATE_LSB +: 7]         = state_q;
    status_word[ST_CONFLICT_BIT]           = guard_enable_i;
  end

  // Zero-wait slave: read data is captured in the address phase, so it stands
  // for the whole data phase; a write is committed in its data phase.
  always_comb
  begin
    act_d    = hsel_i && htrans_i[1] && hready_i;
    wr_d     = hwrite_i && (hsize_i == HSIZE_WORD);
    addr_d   = haddr_i;
    rdata_d  = '0;
    rd_slot  = slot_dec(haddr_i);
    wr_slot  = slot_dec(addr_q);
    period_d = period_q;
    slot_wr  = '0;
    prod_wr  = 1'b0;
    slot_cfg_d = slot_cfg_q;
    if (act_d)  // A write fetches too; the master ignores it then
    begin
      if (haddr_i == ADDR_CONS_COUNT)
        rdata_d = CONS_COUNT_VAL;  // [RULE_15]
      else if (haddr_i == ADDR_PROD_PERIOD)
        rdata_d = {16'h0000, period_q};
      else if (haddr_i == ADDR_STATUS)
        rdata_d = status_word;
      else if (rd_slot[2])
        rdata_d = slot_cfg_q[rd_slot[1:0]];
    end
    if (act_q && wr_q)
    begin
      if (addr_q == ADDR_PROD_PERIOD)
      begin
        period_d = hwdata_i[15:0];
        prod_wr  = 1'b1;
      end
      else if (wr_slot[2])
      begin
        // Reserved top byte is not stored and reads back as zero
        slot_cfg_d[wr_slot[1:0]] = {8'h00, hwdata_i[23:0]};  // [RULE_02] [RULE_01]
        slot_wr[wr_slot[1:0]]    = 1'b1;
      end
    end
  end

  // Configuration is volatile: every reset restores the disabled defaults
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      act_q    <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= '0;
      rdata_q  <= '0;
      period_q <= PROD_RESET;  // [RULE_14] [RULE_16]
      slot_cfg_q <= '{default: SLOT_RESET};  // [RULE_14] [RULE_16]
    end
    else
    begin
      act_q    <= act_d;
      wr_q     <= wr_d;
      addr_q   <= addr_d;
      rdata_q  <= rdata_d;
      period_q <= period_d;
      slot_cfg_q <= slot_cfg_d;
    end
  end

  assign tick      = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));  // [RULE_20]
  assign hb_active = !guard_enable_i;                            // [RULE_12]

  // Timers ignore the node state on purpose, so a stopped node still beats
  always_comb
  begin
    tick_cnt_d = tick ? '0 : tick_cnt_q + TICK_W'(1);
    prod_cnt_d = prod_cnt_q;
    send       = 1'b0;
    rearm      = prod_wr && (hwdata_i[15:0] != 16'h0000);
    expire     = '0;
    armed_d    = armed_q;
    err_d      = err_q;
    state_d    = state_q;
    tx_frame_d = tx_frame_q;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      cons_timer_d[i] = cons_timer_q[i];
      slot_hit[i]     = hb_active && rx_valid_i
                        && (rx_frame_i.id == hb_id(slot_cfg_q[i][SLOT_NODE_LSB +: SLOT_NODE_W]));  // [RULE_10]
      if (slot_wr[i])
      begin
        // New configuration waits again for the first heartbeat
        armed_d[i]      = 1'b0;
        cons_timer_d[i] = '0;
        if (hwdata_i[15:0] != 16'h0000)
        begin
          err_d[i] = 1'b0;
          rearm    = 1'b1;
        end
      end
      else if (slot_cfg_q[i][SLOT_TIME_LSB +: SLOT_TIME_W] == 16'h0000 || !hb_active)
      begin
        armed_d[i]      = 1'b0;  // [RULE_04]
        cons_timer_d[i] = '0;
      end
      else if (slot_hit[i])
      begin
        armed_d[i]      = 1'b1;  // [RULE_05]
        cons_timer_d[i] = slot_cfg_q[i][SLOT_TIME_LSB +: SLOT_TIME_W];  // [RULE_19]
      end
      else if (tick && armed_q[i])
      begin
        if (cons_timer_q[i] <= 16'h0001)  // [RULE_03]
        begin
          expire[i]       = 1'b1;
          armed_d[i]      = 1'b0;
          cons_timer_d[i] = '0;
          err_d[i]        = 1'b1;
        end
        else
          cons_timer_d[i] = cons_timer_q[i] - 16'h0001;
      end
    end
    // Alarm set wins over a clear by re-enabling in the same cycle
    alarm_d = (alarm_q && !rearm) || (|expire);  // [RULE_11] [RULE_06]
    if (period_q == 16'h0000 || !hb_active || prod_wr)  // A period write restarts the count
      prod_cnt_d = '0;  // [RULE_08]
    else if (tick)
    begin
      if (prod_cnt_q >= period_q - 16'h0001)
      begin
        send       = 1'b1;  // [RULE_07]
        prod_cnt_d = '0;
      end
      else
        prod_cnt_d = prod_cnt_q + 16'h0001;
    end
    if (|expire)
      state_d = NODE_PREOP;  // [RULE_06]
    else if (nmt_cmd_valid_i)
    begin
      case (nmt_cmd_i)
        NMT_START: state_d = NODE_OPERATIONAL;  // [RULE_17]
        NMT_STOP:  state_d = NODE_STOPPED;
        NMT_PREOP: state_d = NODE_PREOP;
        default:   state_d = state_q;
      endcase
    end
    // A beat that finds the previous one still waiting replaces it
    tx_pend_d = (tx_pend_q && !tx_ready_i) || send;
    if (send)
      tx_frame_d = '{id: hb_id({1'b0, node_id_i}), data: {1'b0, state_q}};  // [RULE_09]
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_q <= '0;  // [RULE_20]
      prod_cnt_q <= '0;
      armed_q    <= '0;
      err_q      <= '0;
      alarm_q    <= 1'b0;
      state_q    <= NODE_PREOP;
      tx_pend_q  <= 1'b0;
      tx_frame_q <= '0;
      cons_timer_q <= '{default: '0};
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      prod_cnt_q <= prod_cnt_d;
      armed_q    <= armed_d;
      err_q      <= err_d;
      alarm_q    <= alarm_d;
      state_q    <= state_d;
      tx_pend_q  <= tx_pend_d;
      tx_frame_q <= tx_frame_d;
      cons_timer_q <= cons_timer_d;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_expire;
    |expire;
  endsequence

  sequence s_preop_alarm;
    (state_q == NODE_PREOP) && alarm_q;
  endsequence

  chk_zero_timeout_quiet: assert property ( // [RULE_04]
    (slot_cfg_q[1][15:0] == 16'h0000) && $stable(slot_cfg_q[1]) |-> !armed_q[1] && !expire[1])
    else $error("disabled slot is supervising");
  chk_wait_first_beat: assert property ( // [RULE_05]
    !armed_q[0] && !slot_hit[0] |=> !armed_q[0]) else $error("slot armed without a heartbeat");
  chk_hit_reload: assert property ( // [RULE_19]
    slot_hit[0] && !slot_wr[0] && (slot_cfg_q[0][15:0] != 16'h0000)
    |=> armed_q[0] && (cons_timer_q[0] == $past(slot_cfg_q[0][15:0])))
    else $error("heartbeat did not reload slot timer");
  chk_expire_preop: assert property ( // [RULE_06]
    s_expire |=> s_preop_alarm) else $error("timeout did not force preop and alarm");
  chk_tx_format: assert property ( // [RULE_09]
    send |=> tx_valid_o && (tx_frame_o.id == hb_id({1'b0, node_id_i})) && !tx_frame_o.data[7])
    else $error("bad heartbeat frame");
  chk_period_zero: assert property ( // [RULE_08]
    (period_q == 16'h0000) && !tx_valid_o |=> !tx_valid_o) else $error("heartbeat sent with zero period");
  chk_period_elapse: assert property ( // [RULE_07]
    send |-> tick && (prod_cnt_q == period_q - 16'h0001)) else $error("heartbeat sent off period");
  chk_slot_count: assert property ( // [RULE_15]
    act_q && !wr_q && (addr_q == ADDR_CONS_COUNT) |-> hrdata_o == CONS_COUNT_VAL)
    else $error("slot count read wrong");
  chk_rearm_clears: assert property ( // [RULE_11]
    rearm && !(|expire) |=> !alarm_q) else $error("re-enable did not clear alarm");
  chk_guard_excl: assert property ( // [RULE_12]
    guard_enable_i |-> !send && (slot_hit == '0)) else $error("heartbeat active with node guarding");
  chk_reset_zero: assert property ( // [RULE_16]
    $rose(resetn_i) |-> (period_q == 16'h0000) && (slot_cfg_q[3] == 32'h0000_0000))
    else $error("configuration not cleared by reset");

endmodule : heartbeat_error_control

// >>> testbench/can_net_model.sv
// Model of the CAN peers: takes the node's heartbeats, sends remote heartbeats
`timescale 1ns/100ps
module can_net_model
  import heartbeat_pkg::*;
(
  // Clock
  input  wire logic       clock_i,
  // Frames from the node
  input  wire logic       tx_valid_i,
  input  wire can_frame_s tx_frame_i,
  output logic            tx_ready_o,
  // Frames to the node
  output logic            rx_valid_o,
  output can_frame_s      rx_frame_o
);
  int         stall  = 0;
  int         wait_n = 0;
  int         beats  = 0;
  can_frame_s last_frame;

  initial
  begin
    tx_ready_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end

  // Ready only after the chosen stall, so the node has to hold its frame
  always @(posedge clock_i)
  begin
    if (tx_valid_i && tx_ready_o)
    begin
      beats      <= beats + 1;
      last_frame <= tx_frame_i;
    end
    tx_ready_o <= tx_valid_i && !tx_ready_o && wait_n >= stall;
    wait_n     <= (tx_valid_i && !tx_ready_o) ? wait_n + 1 : 0;
  end

  // Idle frame lines carry the inverse, so a stale frame never looks valid
  task automatic send_hb(input logic [6:0] node, input logic [6:0] st);
    @(posedge clock_i);
    rx_valid_o <= 1'b1;
    rx_frame_o <= '{id: HB_ID_BASE + 11'(node), data: {1'b0, st}};
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_frame_o <= ~rx_frame_o;
  endtask : send_hb
endmodule : can_net_model

// >>> testbench/tb_heartbeat_error_control.sv
// Self-checking bench for the heartbeat error-control block
`timescale 1ns/100ps
module tb_heartbeat_error_control
  import heartbeat_pkg::*;
;
  logic        clock_i, resetn_i, hsel, hwrite, hready, hresp;
  logic        nmt_v, guard, pdo, alarm, rx_valid, tx_valid, tx_ready;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  size_sel = HSIZE_WORD;
  logic [6:0]  node_id;
  logic [7:0]  nmt_cmd;
  node_state_e node_state;
  can_frame_s  rx_frame, tx_frame;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cycles    = 0;
  int          n, b;
  logic [31:0] slot_w [4] = '{32'hff22_0005, 32'h0044_0000, 32'h0033_0006, 32'h0055_0009};

  heartbeat_error_control #(.TICK_CYCLES(8)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .node_id_i(node_id), .nmt_cmd_valid_i(nmt_v), .nmt_cmd_i(nmt_cmd),
    .guard_enable_i(guard), .node_state_o(node_state), .pdo_sdo_enable_o(pdo),
    .comm_loss_alarm_o(alarm), .rx_valid_i(rx_valid), .rx_frame_i(rx_frame),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_frame_o(tx_frame));

  can_net_model i_net (
    .clock_i(clock_i), .tx_valid_i(tx_valid), .tx_frame_i(tx_frame),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_frame_o(rx_frame));

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Whole run needs about 550 cycles
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= addr;
    hwrite <= wr_en;
    hsize  <= size_sel;
    @(posedge clock_i iff hready === 1'b1);
    htrans <= 2'b00;
    hwdata <= wdata;
    @(posedge clock_i iff hready === 1'b1);
    rdata = hrdata;
    chk("bus response", {31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    bus(1'b1, addr, data, dummy);
  endtask : wr

  task automatic rd(input logic [31:0] addr, output logic [31:0] data);
    bus(1'b0, addr, 32'h0, data);
  endtask : rd

  task automatic nmt(input logic [7:0] cmd);
    nmt_v   <= 1'b1;
    nmt_cmd <= cmd;
    @(posedge clock_i);
    nmt_v   <= 1'b0;
    @(posedge clock_i);
  endtask : nmt

  // Cycles until the peers accept the next heartbeat
  task automatic wait_beat(output int cnt);
    int start = i_net.beats;
    cnt = 0;
    while (i_net.beats == start && cnt < 400)
    begin
      @(posedge clock_i);
      cnt++;
    end
  endtask : wait_beat

  initial
  begin
    resetn_i = 1'b0;
    hsel     = 1'b0;
    haddr    = '0;
    htrans   = '0;
    hwrite   = 1'b0;
    hsize    = '0;
    hwdata   = '0;
    node_id  = 7'h2a;
    nmt_v    = 1'b0;
    nmt_cmd  = '0;
    guard    = 1'b0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);

    rd(ADDR_CONS_COUNT, rv);
    chk("slot count", rv, 32'h4);
    wr(ADDR_CONS_COUNT, 32'hffff);
    rd(ADDR_CONS_COUNT, rv);
    chk("slot count ro", rv, 32'h4);
    rd(ADDR_PROD_PERIOD, rv);
    chk("period reset", rv, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd(ADDR_SLOT_BASE + 32'(4 * i), rv);
      chk("slot reset", rv, 32'h0);
    end
    rd(ADDR_STATUS, rv);
    chk("reset state", rv[22:16], 32'h7f);
    wr(32'h0000_4080, 32'h1);
    rd(32'h0000_4080, rv);
    chk("unmapped", rv, 32'h0);
    size_sel = 3'h1;
    wr(ADDR_PROD_PERIOD, 32'h7);
    size_sel = HSIZE_WORD;
    rd(ADDR_PROD_PERIOD, rv);
    chk("short write", rv, 32'h0);
    $display("test registers done");

    repeat (80) @(posedge clock_i);
    chk("beats disabled", i_net.beats, 32'h0);
    wr(ADDR_PROD_PERIOD, 32'h3);
    wait_beat(n);
    wait_beat(n);
    chk("beat interval", n, 32'd24);
    chk("beat frame", i_net.last_frame, {11'h72a, 8'h7f});
    nmt(NMT_STOP);
    chk("stopped", node_state, 32'h4);
    chk("pdo sdo off", pdo, 32'h0);
    i_net.stall = 3;
    wait_beat(n);
    wait_beat(n);
    chk("stopped interval", n, 32'd24);
    chk("stopped frame", i_net.last_frame, {11'h72a, 8'h04});
    nmt(NMT_START);
    chk("operational", node_state, 32'h5);
    chk("pdo sdo on", pdo, 32'h1);
    $display("test producer done");

    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_SLOT_BASE + 32'(4 * i), slot_w[i]);
      rd(ADDR_SLOT_BASE + 32'(4 * i), rv);
      chk("slot word", rv, {8'h00, slot_w[i][23:0]});
    end
    i_net.send_hb(7'h44, NODE_OPERATIONAL);
    repeat (80) @(posedge clock_i);
    chk("quiet slots", alarm, 32'h0);
    repeat (3)
    begin
      i_net.send_hb(7'h22, NODE_OPERATIONAL);
      repeat (22) @(posedge clock_i);
    end
    chk("fed slot", alarm, 32'h0);
    i_net.send_hb(7'h22, NODE_OPERATIONAL);
    n = 0;
    while (alarm !== 1'b1 && n < 200)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("expiry time", 32'(n >= 32 && n <= 42), 32'h1);
    chk("expiry state", node_state, 32'h7f);
    rd(ADDR_STATUS, rv);
    chk("status", rv[8:0], 32'h101);
    wr(ADDR_PROD_PERIOD, 32'h3);
    @(posedge clock_i);
    chk("alarm cleared", alarm, 32'h0);
    $display("test consumer done");

    guard <= 1'b1;
    repeat (10) @(posedge clock_i);
    b = i_net.beats;
    repeat (80) @(posedge clock_i);
    chk("guard blocks", i_net.beats, 32'(b));
    rd(ADDR_STATUS, rv);
    chk("guard status", {rv[24], rv[7:4]}, 32'h10);
    guard <= 1'b0;
    $display("test guard done");

    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    rd(ADDR_PROD_PERIOD, rv);
    chk("period after reset", rv, 32'h0);
    rd(ADDR_SLOT_BASE, rv);
    chk("slot after reset", rv, 32'h0);
    chk("state after reset", node_state, 32'h7f);
    chk("alarm after reset", alarm, 32'h0);
    $display("test reset done");
    final_report();
  end
endmodule : tb_heartbeat_error_control
